// ===== src/tdu_dma.sv
// Our own choice: the APB register port.
`timescale 1ns/1ns
// Function
// - two channels, one selected request source each
// - any memory/io source and destination pairing
// - byte or word units, any address alignment
// - read then write, never split apart
// - count drops by one per transfer
// - destination pointer drives address lines
// - source pointer drives address lines
// - bit 15 picks destination space
// - bits 14/13 step destination pointer
// - bit 12 picks source space
// - bits 11/10 step source pointer
// - stop at zero count per bit 9 when paced; unpaced channels always stop
// - terminal count interrupt when bits 8,9 set
// - bits 7..6 choose pacing mode
// - software changes run bit only with guard bit
// - bit 0 chooses word or byte units
// - bit 5 gives channel precedence
// - bit 4 enables timer 2 requests
module tdu_dma
  import tdu_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  // apb slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  input  wire logic [3:0]        i_pstrb,
  output logic [31:0]            o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // request sources
  input  wire logic [1:0]        i_ext_request,
  input  wire logic [1:0]        i_serial_owns,
  input  wire logic [1:0]        i_serial_request,
  input  wire logic              i_timer2_overflow,
  // system bus master
  output logic                   o_bus_hold,
  output tdu_bus_req_t           o_bus,
  input  wire logic              i_bus_ack,
  input  wire logic [WORD_W-1:0] i_bus_rdata,
  // terminal count interrupt requests
  output logic [1:0]             o_irq
);

  // whole module state in one record
  typedef struct packed {
    tdu_chan_t [1:0]   ch;          // channel registers
    tdu_state_t        state;       // transfer engine phase
    logic              act;         // channel owning the transfer
    logic [WORD_W-1:0] data;        // word carried from read to write
    logic [1:0][2:0]   pin_sync;    // three-stage pin synchronisers
    logic [1:0]        pin_level;   // filtered request pin levels
    logic [31:0]       prdata;      // registered read data
    logic              pslverr;     // registered error answer
    logic [1:0]        irq;         // one-cycle interrupt pulses
  } tdu_dma_state_t;

  tdu_dma_state_t s_ff;             // registered state
  tdu_dma_state_t nxt_s;            // its next value

  // next pointer value after one transfer; both step bits hold it
  function automatic logic [PTR_W-1:0] step_ptr(input logic [PTR_W-1:0] p,
                                                input logic down,
                                                input logic up,
                                                input logic word);
    logic [PTR_W-1:0] st;
    st = word ? STEP_WORD : STEP_BYTE;
    if (down && !up) begin
      step_ptr = p - st;
    end else if (up && !down) begin
      step_ptr = p + st;
    end else begin
      step_ptr = p;
    end
  endfunction

  // byte-lane merge of a 16-bit register
  function automatic logic [WORD_W-1:0] merge16(input logic [WORD_W-1:0] old,
                                                input logic [31:0] wd,
                                                input logic [3:0] strb);
    merge16 = old;
    if (strb[0]) begin
      merge16[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      merge16[15:8] = wd[15:8];
    end
  endfunction

  // register match: word-aligned base index, either channel
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [7:0] base);
    reg_hit = (a[1:0] == 2'h0) && ((a[9:2] & IDX_CH_MASK) == base);
  endfunction

  // channel request level from its one selected source
  function automatic logic chan_req(input tdu_chan_t c,
                                    input logic pin,
                                    input logic owns,
                                    input logic ser);
    if (c.ctrl.timer_request_enable) begin
      chan_req = c.timer_pending;
    end else if (owns) begin
      chan_req = ser;
    end else begin
      chan_req = pin;
    end
  endfunction

  // true when this transfer empties the count and the channel must halt;
  // unpaced channels always halt there, paced ones only with the stop bit
  function automatic logic tc_stop(input tdu_ctrl_t ctl,
                                   input logic [WORD_W-1:0] cnt);
    tc_stop = (cnt == COUNT_ZERO) &&
              (ctl.pacing_type == PACE_UNSYNC || ctl.terminal_count_stop);
  endfunction

  logic [1:0]        want;          // channel ready to start a transfer
  logic              pick;          // arbitration winner
  logic              sel;           // apb channel select
  logic              wr_acc;        // apb write in its access phase
  logic [WORD_W-1:0] count_dec;     // count after the current transfer
  tdu_chan_t         a;             // active channel copy
  tdu_ctrl_t         wr_ctl;        // control word as software writes it

  // state update
  always_comb begin
    nxt_s = s_ff;
    nxt_s.irq = '0;
    want = '0;
    pick = 1'b0;
    // channel 1 registers sit one index step above channel 0
    sel = |(i_paddr[ADDR_W-1:2] & IDX_CH_STEP);
    wr_acc = i_psel && i_penable && i_pwrite;
    wr_ctl = tdu_ctrl_t'(i_pwdata[WORD_W-1:0]);
    a = s_ff.ch[s_ff.act];
    count_dec = a.xfer_count - COUNT_ONE;

    // pins: first stage only feeds the second; level moves when 2nd and 3rd agree
    for (int c = 0; c < 2; c++) begin
      nxt_s.pin_sync[c] = {s_ff.pin_sync[c][1:0], i_ext_request[c]};
      if (s_ff.pin_sync[c][1] == s_ff.pin_sync[c][2]) begin
        nxt_s.pin_level[c] = s_ff.pin_sync[c][2];
      end
      // unsynchronised channels run free; paced ones wait for a request
      want[c] = s_ff.ch[c].ctrl.run_channel &&
                (s_ff.ch[c].ctrl.pacing_type == PACE_UNSYNC ||
                 chan_req(s_ff.ch[c], s_ff.pin_level[c], i_serial_owns[c], i_serial_request[c]));
    end

    // channel 1 wins only when it alone holds precedence or channel 0 is quiet
    if (want[1] && (!want[0] || (s_ff.ch[1].ctrl.priority_hi && !s_ff.ch[0].ctrl.priority_hi))) begin
      pick = 1'b1;
    end

    // transfer engine
    case (s_ff.state)
      ST_IDLE: begin
        // the idle cycle after each write lets the updated run bit gate the next start
        if (want != 2'h0) begin
          nxt_s.act = pick;
          nxt_s.ch[pick].timer_pending = 1'b0;
          nxt_s.state = ST_READ;
        end
      end
      ST_READ: begin
        // no other channel can start until the write ends
        if (i_bus_ack) begin
          nxt_s.data = i_bus_rdata;
          nxt_s.state = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (i_bus_ack) begin
          nxt_s.ch[s_ff.act].src_ptr = step_ptr(a.src_ptr, a.ctrl.src_pointer_down,
                                                a.ctrl.src_pointer_up, a.ctrl.word_units);
          nxt_s.ch[s_ff.act].dst_ptr = step_ptr(a.dst_ptr, a.ctrl.dst_pointer_down,
                                                a.ctrl.dst_pointer_up, a.ctrl.word_units);
          nxt_s.ch[s_ff.act].xfer_count = count_dec;
          if (count_dec == COUNT_ZERO) begin
            // paced channels only stop with the stop bit set
            if (tc_stop(a.ctrl, count_dec)) begin
              nxt_s.ch[s_ff.act].ctrl.run_channel = 1'b0;
            end
            if (a.ctrl.irq_enable && a.ctrl.terminal_count_stop) begin
              nxt_s.irq[s_ff.act] = 1'b1;
            end
          end
          nxt_s.state = ST_IDLE;
        end
      end
      default: begin
        nxt_s.state = ST_IDLE;
      end
    endcase

    // timer overflow latches after consumption so a same-cycle event survives
    for (int c = 0; c < 2; c++) begin
      if (i_timer2_overflow && s_ff.ch[c].ctrl.timer_request_enable) begin
        nxt_s.ch[c].timer_pending = 1'b1;
      end
    end

    // apb setup phase: capture read data and error answer
    if (i_psel && !i_penable) begin
      nxt_s.pslverr = 1'b0;
      nxt_s.prdata = '0;
      if (reg_hit(i_paddr, IDX_CTRL)) begin
        nxt_s.prdata[WORD_W-1:0] = s_ff.ch[sel].ctrl;
      end else if (reg_hit(i_paddr, IDX_COUNT)) begin
        nxt_s.prdata[WORD_W-1:0] = s_ff.ch[sel].xfer_count;
      end else if (reg_hit(i_paddr, IDX_DST_HI)) begin
        nxt_s.prdata[HI_W-1:0] = s_ff.ch[sel].dst_ptr[PTR_W-1:WORD_W];
      end else if (reg_hit(i_paddr, IDX_DST_LO)) begin
        nxt_s.prdata[WORD_W-1:0] = s_ff.ch[sel].dst_ptr[WORD_W-1:0];
      end else if (reg_hit(i_paddr, IDX_SRC_HI)) begin
        nxt_s.prdata[HI_W-1:0] = s_ff.ch[sel].src_ptr[PTR_W-1:WORD_W];
      end else if (reg_hit(i_paddr, IDX_SRC_LO)) begin
        nxt_s.prdata[WORD_W-1:0] = s_ff.ch[sel].src_ptr[WORD_W-1:0];
      end else begin
        nxt_s.pslverr = 1'b1;                                           // unmapped
      end
    end

    // apb access phase write; software wins over a same-cycle hardware update
    // pointers written while their channel runs move the live bus address; stop it first
    if (wr_acc && !s_ff.pslverr) begin
      if (reg_hit(i_paddr, IDX_CTRL)) begin
        nxt_s.ch[sel].ctrl = merge16(s_ff.ch[sel].ctrl, i_pwdata, i_pstrb);
        nxt_s.ch[sel].ctrl.reserved3 = 1'b0;
        nxt_s.ch[sel].ctrl.run_bit_write_guard = 1'b0;
        // without the guard bit the run bit keeps its value
        if (!(i_pstrb[0] && wr_ctl.run_bit_write_guard)) begin
          nxt_s.ch[sel].ctrl.run_channel = s_ff.ch[sel].ctrl.run_channel;
          // a terminal stop landing in this very cycle must not be undone
          if (s_ff.state == ST_WRITE && i_bus_ack && s_ff.act == sel && tc_stop(a.ctrl, count_dec)) begin
            nxt_s.ch[sel].ctrl.run_channel = 1'b0;
          end
        end
      end else if (reg_hit(i_paddr, IDX_COUNT)) begin
        nxt_s.ch[sel].xfer_count = merge16(s_ff.ch[sel].xfer_count, i_pwdata, i_pstrb);
      end else if (reg_hit(i_paddr, IDX_DST_HI)) begin
        if (i_pstrb[0]) begin
          nxt_s.ch[sel].dst_ptr[PTR_W-1:WORD_W] = i_pwdata[HI_W-1:0];
        end
      end else if (reg_hit(i_paddr, IDX_DST_LO)) begin
        nxt_s.ch[sel].dst_ptr[WORD_W-1:0] = merge16(s_ff.ch[sel].dst_ptr[WORD_W-1:0], i_pwdata, i_pstrb);
      end else if (reg_hit(i_paddr, IDX_SRC_HI)) begin
        if (i_pstrb[0]) begin
          nxt_s.ch[sel].src_ptr[PTR_W-1:WORD_W] = i_pwdata[HI_W-1:0];
        end
      end else if (reg_hit(i_paddr, IDX_SRC_LO)) begin
        nxt_s.ch[sel].src_ptr[WORD_W-1:0] = merge16(s_ff.ch[sel].src_ptr[WORD_W-1:0], i_pwdata, i_pstrb);
      end
    end
  end

  // every register clears together so no half-programmed channel survives reset
  // single state register, synchronous reset; stopped channels keep values
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // bus drive: read phase uses source, write phase destination
  always_comb begin
    o_bus = '0;
    o_bus_hold = (s_ff.state != ST_IDLE);
    o_bus.word = a.ctrl.word_units;
    case (s_ff.state)
      ST_READ: begin
        o_bus.cyc = 1'b1;
        o_bus.mem = a.ctrl.src_in_memory;
        o_bus.addr = a.src_ptr;
      end
      ST_WRITE: begin
        o_bus.cyc = 1'b1;
        o_bus.write = 1'b1;
        o_bus.mem = a.ctrl.dst_in_memory;
        o_bus.addr = a.dst_ptr;
        o_bus.wdata = s_ff.data;
      end
      default: begin
        o_bus.word = 1'b0;                                              // bus released
      end
    endcase
  end

  // apb answers: zero wait, data captured during setup
  // a registered decode keeps the address path out of the ready timing
  assign o_pready  = 1'b1;
  assign o_prdata  = s_ff.prdata;
  assign o_pslverr = s_ff.pslverr && i_psel && i_penable;
  assign o_irq     = s_ff.irq;

endmodule

// ===== src/tdu_pkg.sv
package tdu_pkg;
  // apb address: byte address = register index * 4
  localparam int unsigned ADDR_W = 10;
  // register indices of channel 0; channel 1 sits one step above
  localparam logic [7:0] IDX_SRC_LO  = 8'hc0;
  localparam logic [7:0] IDX_SRC_HI  = 8'hc2;
  localparam logic [7:0] IDX_DST_LO  = 8'hc4;
  localparam logic [7:0] IDX_DST_HI  = 8'hc6;
  localparam logic [7:0] IDX_COUNT   = 8'hc8;
  localparam logic [7:0] IDX_CTRL    = 8'hca;
  localparam logic [7:0] IDX_CH_STEP = 8'h10;
  localparam logic [7:0] IDX_CH_MASK = 8'hef;
  localparam int unsigned PTR_W   = 20;
  localparam int unsigned HI_W    = 4;
  localparam int unsigned WORD_W  = 16;
  localparam logic [PTR_W-1:0] STEP_BYTE = 20'h00001;
  localparam logic [PTR_W-1:0] STEP_WORD = 20'h00002;
  localparam logic [WORD_W-1:0] COUNT_ONE = 16'h0001;
  localparam logic [WORD_W-1:0] COUNT_ZERO = 16'h0000;

  // pacing codes
  localparam logic [1:0] PACE_UNSYNC = 2'h0;
  localparam logic [1:0] PACE_SRC    = 2'h1;
  localparam logic [1:0] PACE_DST    = 2'h2;

  // control word, msb first, one field per bit except the two-bit pacing_type
  typedef struct packed {
    logic       dst_in_memory;
    logic       dst_pointer_down;
    logic       dst_pointer_up;
    logic       src_in_memory;
    logic       src_pointer_down;
    logic       src_pointer_up;
    logic       terminal_count_stop;
    logic       irq_enable;
    logic [1:0] pacing_type;
    logic       priority_hi;
    logic       timer_request_enable;
    logic       reserved3;
    logic       run_bit_write_guard;
    logic       run_channel;
    logic       word_units;
  } tdu_ctrl_t;

  // per-channel state
  typedef struct packed {
    tdu_ctrl_t               ctrl;
    logic [WORD_W-1:0]       xfer_count;
    logic [PTR_W-1:0]        dst_ptr;
    logic [PTR_W-1:0]        src_ptr;
    logic                    timer_pending;
  } tdu_chan_t;

  // system bus request toward the bus interface
  typedef struct packed {
    logic              cyc;
    logic              write;
    logic              mem;
    logic              word;
    logic [PTR_W-1:0]  addr;
    logic [WORD_W-1:0] wdata;
  } tdu_bus_req_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10
  } tdu_state_t;
endpackage

// ===== sim/tdu_properties.sv
`timescale 1ns/1ns
// watches the dma bus master and the apb slave from the top ports only
module tdu_properties
  import tdu_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  input  wire logic              o_pready,
  input  wire logic              o_bus_hold,
  input  wire tdu_bus_req_t      o_bus,
  input  wire logic              i_bus_ack,
  input  wire logic [WORD_W-1:0] i_bus_rdata,
  input  wire logic [1:0]        o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // phase completions and the start of the write phase
  sequence s_rd_ack; o_bus.cyc && !o_bus.write && i_bus_ack; endsequence
  sequence s_wr_ack; o_bus.cyc && o_bus.write && i_bus_ack; endsequence
  sequence s_wr_on; o_bus.cyc && o_bus.write && o_bus_hold; endsequence
  AST_ZERO_WAIT: assert property (o_pready)
    else $error("apb slave added a wait state");
  AST_IDLE_FREE: assert property (!o_bus_hold |-> !o_bus.cyc)
    else $error("bus cycle outside a held transfer");
  AST_READ_FIRST: assert property ($rose(o_bus_hold) |-> o_bus.cyc && !o_bus.write)
    else $error("transfer did not open with a read");
  AST_WRITE_NEXT: assert property (s_rd_ack |=> s_wr_on)
    else $error("write phase did not follow the read at once");
  AST_PHASE_STEADY: assert property (o_bus.cyc && !i_bus_ack |=>
    o_bus.cyc && $stable({o_bus.write, o_bus.mem, o_bus.word, o_bus.addr}))
    else $error("bus phase changed before its ack");
  AST_WRITE_LAST: assert property (s_wr_ack |=> !o_bus.cyc && !o_bus_hold)
    else $error("bus not released after the write");
  AST_WORD_COPY: assert property ((s_rd_ack ##1 o_bus.word) |-> o_bus.wdata == $past(i_bus_rdata))
    else $error("word written differs from word read");
  AST_IRQ_CAUSE: assert property (o_irq != 2'b00 |-> $past(o_bus.cyc && o_bus.write && i_bus_ack))
    else $error("irq without a finished write");
  AST_IRQ_PULSE: assert property (o_irq != 2'b00 |=> o_irq == 2'b00)
    else $error("irq longer than one cycle");
endmodule

// ===== sim/tdu_bus_model.sv
`timescale 1ns/1ns
// system bus slave: answers each phase after i_wait+1 idle cycles
module tdu_bus_model
  import tdu_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  input  wire tdu_bus_req_t      i_bus,
  input  wire logic [1:0]        i_wait,
  output logic                   o_bus_ack,
  output logic [WORD_W-1:0]      o_bus_rdata
);
  logic [1:0]        wait_ff;  // cycles already waited in this phase
  logic [WORD_W-1:0] last_ff;  // value left on the data lines last cycle
  // read data is a scramble of the address; released lines toggle each
  // cycle so a master sampling outside the read never sees a stale match
  assign o_bus_rdata = (i_bus.cyc && !i_bus.write) ? i_bus.addr[15:0] ^ 16'ha5c3 : ~last_ff;
  // one-cycle ack per phase; the pulse itself blocks a second ack
  always @(posedge i_clk) begin
    last_ff   <= i_resetn ? o_bus_rdata : 16'h0000;
    o_bus_ack <= i_resetn && i_bus.cyc && !o_bus_ack && wait_ff == i_wait;
    if (!i_resetn || !i_bus.cyc || o_bus_ack || wait_ff == i_wait) begin
      wait_ff <= 2'h0;
    end else begin
      wait_ff <= wait_ff + 2'h1;
    end
  end
endmodule

// ===== sim/two_channel_dma_unit_tb.sv
`timescale 1ns/1ns
// self-checking bench: apb registers, paced and free transfers, priority
module two_channel_dma_unit_tb
  import tdu_pkg::*;
;
  typedef struct packed {
    logic [PTR_W-1:0] sa;
    logic             sm;
    logic [PTR_W-1:0] da;
    logic             dm;
    logic             w;
  } tdu_note_t;
  localparam logic [7:0] DDIR = 8'b01_11_10_01;  // dst step code per config
  localparam logic [7:0] SDIR = 8'b01_01_11_10;  // src step code per config
  logic i_clk = 1'b0, i_resetn = 1'b0, psel, penable, pwrite, pready, pslverr, tmr, hold, ack;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata;
  logic [1:0]        ext_req, ser_owns, ser_req, irq, wait_sel;
  tdu_bus_req_t      bus;
  logic [WORD_W-1:0] rdata;
  logic [PTR_W-1:0]  ra;  // address of the last acked read
  logic              rm;  // space of the last acked read
  int error_cnt = 0, checked = 0, cyc_cnt = 0, irq0 = 0, irq1 = 0;
  integer seed = 32'h1eae3462;
  tdu_note_t   bq[$];  // expected transfers, oldest first
  logic [32:0] rq[$];  // expected {pslverr, prdata}
  tdu_dma dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'h3), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_ext_request(ext_req), .i_serial_owns(ser_owns), .i_serial_request(ser_req),
    .i_timer2_overflow(tmr), .o_bus_hold(hold), .o_bus(bus), .i_bus_ack(ack), .i_bus_rdata(rdata), .o_irq(irq));
  tdu_bus_model bus_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_bus(bus), .i_wait(wait_sel),
    .o_bus_ack(ack), .o_bus_rdata(rdata));
  always #4 i_clk = ~i_clk;
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // monitor: pops the oldest note whenever a read or a transfer completes
  always @(posedge i_clk) begin
    if (psel && penable && pready && !pwrite) begin
      chk(rq.size() != 0 && {pslverr, prdata} === rq[0], "apb read data");
      if (rq.size() != 0) void'(rq.pop_front());
    end
    if (bus.cyc && ack && !bus.write) begin
      ra = bus.addr;
      rm = bus.mem;
    end
    if (bus.cyc && ack && bus.write) begin
      chk(bq.size() != 0 && {ra, rm, bus.addr, bus.mem, bus.word} === bq[0], "transfer addresses");
      if (bus.word === 1'b1) chk(bus.wdata === (ra[15:0] ^ 16'ha5c3), "word data");
      if (bq.size() != 0) void'(bq.pop_front());
    end
    irq0 += int'(irq[0] === 1'b1);
    irq1 += int'(irq[1] === 1'b1);
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  // one apb transfer; the request stands until pready is seen
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [15:0] d);
    @(posedge i_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {idx, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge i_clk);
    penable <= 1'b1;
    @(posedge i_clk);
    while (pready !== 1'b1) @(posedge i_clk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, input logic err, input logic [15:0] d);
    rq.push_back({err, 16'h0000, d});
    apb(1'b0, idx, 16'h0000);
  endtask
  function automatic logic [7:0] ix(input logic ch, input logic [7:0] b);
    return b + (ch ? IDX_CH_STEP : 8'h00);
  endfunction
  // signed pointer step for a {down, up} code
  function automatic logic [PTR_W-1:0] step(input logic [1:0] dir, input logic w);
    logic [PTR_W-1:0] st;
    st = w ? STEP_WORD : STEP_BYTE;
    return dir == 2'b01 ? st : (dir == 2'b10 ? -st : '0);
  endfunction
  function automatic tdu_ctrl_t go();
    tdu_ctrl_t c;
    c = '0;
    c.terminal_count_stop = 1'b1;
    c.run_bit_write_guard = 1'b1;
    c.run_channel = 1'b1;
    return c;
  endfunction
  task automatic prog(input logic ch, input logic [PTR_W-1:0] s, input logic [PTR_W-1:0] d,
                      input logic [15:0] n, input tdu_ctrl_t c);
    apb(1'b1, ix(ch, IDX_SRC_LO), s[15:0]);
    apb(1'b1, ix(ch, IDX_SRC_HI), {12'h000, s[19:16]});
    apb(1'b1, ix(ch, IDX_DST_LO), d[15:0]);
    apb(1'b1, ix(ch, IDX_DST_HI), {12'h000, d[19:16]});
    apb(1'b1, ix(ch, IDX_COUNT), n);
    apb(1'b1, ix(ch, IDX_CTRL), c);
  endtask
  // waits for every noted transfer, then for the bus to go quiet
  task automatic settle();
    @(posedge i_clk);
    while (bq.size() != 0 || hold !== 1'b0) @(posedge i_clk);
    repeat (4) @(posedge i_clk);
  endtask
  initial begin
    tdu_ctrl_t c;
    logic [PTR_W-1:0] s, d, ss, ds;
    {psel, penable, pwrite, paddr, pwdata, tmr} = '0;
    {ext_req, ser_owns, ser_req, wait_sel} = '0;
    repeat (10) @(posedge i_clk);
    i_resetn <= 1'b1;
    rd(ix(0, IDX_CTRL), 1'b0, 16'h0000);
    rd(ix(1, IDX_COUNT), 1'b0, 16'h0000);
    apb(1'b1, ix(1, IDX_SRC_HI), 16'hfffa);
    rd(ix(1, IDX_SRC_HI), 1'b0, 16'h000a);
    rd(8'h00, 1'b1, 16'h0000);
    apb(1'b1, ix(0, IDX_CTRL), 16'h0002);  // run bit without its guard
    rd(ix(0, IDX_CTRL), 1'b0, 16'h0000);
    $display("test registers done");
    // free running transfers over all space pairings, steps and units
    for (int i = 0; i < 4; i++) begin
      wait_sel <= i[1:0];
      s = 20'($random(seed));
      d = 20'($random(seed));
      if (!i[0]) s[19:16] = 4'h0;
      if (!i[1]) d[19:16] = 4'h0;
      c = go();
      c.terminal_count_stop = (i != 1);
      c.irq_enable = 1'b1;
      c.dst_in_memory = i[1];
      c.src_in_memory = i[0];
      c.word_units = i[0];
      {c.dst_pointer_down, c.dst_pointer_up} = DDIR[2*i +: 2];
      {c.src_pointer_down, c.src_pointer_up} = SDIR[2*i +: 2];
      ds = step(DDIR[2*i +: 2], i[0]);
      ss = step(SDIR[2*i +: 2], i[0]);
      bq.push_back({s, i[0], d, i[1], i[0]});
      bq.push_back({s + ss, i[0], d + ds, i[1], i[0]});
      prog(1'b0, s, d, 16'h0002, c);
      settle();
      rd(ix(0, IDX_COUNT), 1'b0, 16'h0000);
      s = s + ss + ss;
      d = d + ds + ds;
      rd(ix(0, IDX_SRC_LO), 1'b0, s[15:0]);
      rd(ix(0, IDX_DST_LO), 1'b0, d[15:0]);
      rd(ix(0, IDX_CTRL), 1'b0, 16'(c) & 16'hfff9);
    end
    chk(irq0 == 3, "terminal count irq");
    $display("test transfers done");
    // paced channel fed by pin, serial port, then timer; others ignored
    for (int k = 0; k < 3; k++) begin
      s = {4'h0, 16'($random(seed))};
      c = go();
      c.src_in_memory = 1'b1;
      c.pacing_type = PACE_SRC;
      c.timer_request_enable = (k == 2);
      ser_owns <= {1'b0, k == 1};
      prog(1'b0, s, s, 16'h0001, c);
      ext_req <= {1'b0, k != 0};
      tmr <= (k != 2);
      @(posedge i_clk);
      tmr <= 1'b0;
      repeat (12) @(posedge i_clk);
      bq.push_back({s, 1'b1, s, 1'b0, 1'b0});
      ext_req <= {1'b0, k == 0};
      ser_req <= {1'b0, k == 1};
      tmr <= (k == 2);
      @(posedge i_clk);
      tmr <= 1'b0;
      settle();
      {ext_req, ser_req} <= '0;
    end
    $display("test sources done");
    // both pins at once: the channel with precedence goes first
    wait_sel <= 2'h3;
    s = {4'h0, 16'($random(seed))};
    d = {4'h0, 16'($random(seed))};
    c = go();
    c.src_in_memory = 1'b1;
    c.pacing_type = PACE_DST;
    prog(1'b0, s, d, 16'h0001, c);
    c.pacing_type = PACE_SRC;
    c.priority_hi = 1'b1;
    c.irq_enable = 1'b1;
    prog(1'b1, d, s, 16'h0001, c);
    bq.push_back({d, 1'b1, s, 1'b0, 1'b0});
    bq.push_back({s, 1'b1, d, 1'b0, 1'b0});
    ext_req <= 2'b11;
    settle();
    ext_req <= 2'b00;
    chk(irq1 == 1, "irq of second channel");
    $display("test priority done");
    wrap_up();
  end
endmodule
bind tdu_dma tdu_properties chk_u (.i_clk(i_clk), .i_resetn(i_resetn), .o_pready(o_pready),
  .o_bus_hold(o_bus_hold), .o_bus(o_bus), .i_bus_ack(i_bus_ack), .i_bus_rdata(i_bus_rdata), .o_irq(o_irq));
